//--- shared/mall_pkg.sv
// Purpose: Constants and types for the MAC address lookup and learning block
// Assumes: 250 MHz core clock, 512-entry table indexed by address hash
// Notes: Entry layout is shared by write data, read data and table storage

package mall_pkg;

  // ==========================================================================
  // Table geometry
  localparam int TBL_DEPTH = 512;
  localparam int IDX_W = 9;
  localparam int ENT_W = 59;
  localparam int NUM_PORTS = 3;

  // ==========================================================================
  // Entry field positions (high data word holds entry bits 58..32)
  localparam int F_MAC_HI = 47;
  localparam int F_PORTS_LO = 48;
  localparam int F_PORTS_HI = 50;
  localparam int F_AGE = 51;
  localparam int F_STATIC = 52;
  localparam int F_FILTER = 53;
  localparam int F_PRIO_EN = 54;
  localparam int F_PRIO_LO = 55;
  localparam int F_PRIO_HI = 57;
  localparam int F_VALID = 58;
  localparam int HI_OFS = 32;
  localparam int RDH_EOT = 27;

  // ==========================================================================
  // Command word bits
  localparam int CMD_GET_NEXT = 0;
  localparam int CMD_GET_FIRST = 1;
  localparam int CMD_MAKE = 2;
  localparam logic [31:0] CMD_MAKE_VAL = 32'h0000_0004;
  localparam logic [31:0] CMD_FIRST_VAL = 32'h0000_0002;
  localparam logic [31:0] CMD_NEXT_VAL = 32'h0000_0001;
  localparam logic [31:0] CMD_IDLE_VAL = 32'h0000_0000;

  // ==========================================================================
  // Aging period
  localparam longint CLK_HZ = 64'd250_000_000;
  localparam longint AGE_PERIOD_S = 64'd300;
  localparam longint AGE_PERIOD_CYC = AGE_PERIOD_S * CLK_HZ;
  localparam int AGE_CNT_W = 40;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    ST_INIT, ST_IDLE, ST_LOOK, ST_LEARN, ST_MAKE, ST_AGE, ST_SCAN
  } mall_state_type;

  typedef struct packed {
    mall_state_type state;
    logic [IDX_W-1:0] idx;
    logic [IDX_W:0] scan_ptr;
    logic [AGE_CNT_W-1:0] age_cnt;
    logic age_req;
    logic scan_req;
    logic make_pend;
    logic [47:0] dmac;
    logic [47:0] smac;
    logic [1:0] sport;
    logic [31:0] wdl;
    logic [31:0] wdh;
    logic [31:0] rdl;
    logic [31:0] rdh;
    logic ready;
    logic done;
    logic hit;
    logic [NUM_PORTS-1:0] ports;
    logic filter;
    logic prio_valid;
    logic [2:0] prio;
    logic stp_ovr;
  } mall_ctl_type;

endpackage : mall_pkg

//--- src/mall_hash.sv
// Purpose: Folds a 48-bit MAC address into a 9-bit table index
// Assumes: Pure combinational, used for lookup, learning and host entry
// Notes: XOR fold spreads vendor-prefix clustering across the table

`timescale 1ns/10ps

module mall_hash (
  input wire logic [47:0] mac,
  output logic [mall_pkg::IDX_W-1:0] idx
);

  // ==========================================================================
  // Fold
  assign idx = mac[8:0] ^ mac[17:9] ^ mac[26:18] ^ mac[35:27] ^ mac[44:36]
             ^ {6'h00, mac[47:45]};

endmodule : mall_hash

//--- src/mall_table.sv
// Purpose: MAC address table with lookup, learning, aging and host access
// Assumes: Host command and data registers are written through strobes
// Notes: One entry per hash slot, so table reads return slot order
//
// Functional notes
// - Hold 512 entries; destination lookup returns ports, filter, priority, override
// - Learn unknown source address with its receive port
// - Known learned source refreshes port and sets the age bit
// - No learning on ports whose learning enable is clear
// - Each aging scan clears set age bits, removes learned entries already clear
// - Aging period about five minutes, removal between five and ten minutes
// - Static entries never aged nor changed by learning
// - Destination may be any combination of ports
// - Hit on entry with filter bit reports packet filtered
// - Static plus age bits give spanning tree override
// - Stored priority used only with global and entry enables
// - Make-entry command 0004h commits the write data, then 0000h
// - Make-entry with valid clear deletes the matching entry
// - Get-first 0002h presents the first stored entry
// - Read high word shows valid or end-of-table
// - Get-next 0001h presents the following entry or end-of-table
// - Read order need not match learning order

`timescale 1ns/10ps

module mall_table #(
  parameter longint AGE_PERIOD_CYCLES = mall_pkg::AGE_PERIOD_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  // Packet path
  input wire logic lkp_req,
  input wire logic [47:0] lkp_dst_mac,
  input wire logic [47:0] lkp_src_mac,
  input wire logic [1:0] lkp_src_port,
  output logic lkp_ready,
  output logic lkp_done,
  output logic lkp_hit,
  output logic [mall_pkg::NUM_PORTS-1:0] lkp_ports,
  output logic lkp_filter,
  output logic lkp_prio_valid,
  output logic [2:0] lkp_prio,
  output logic lkp_stp_override,
  // Configuration
  input wire logic [mall_pkg::NUM_PORTS-1:0] port_learn_en,
  input wire logic global_addr_prio_en,
  // Host registers
  input wire logic cmd_wr,
  input wire logic [31:0] cmd_wdata,
  input wire logic wdl_wr,
  input wire logic wdh_wr,
  input wire logic [31:0] host_wdata,
  output logic make_pending,
  output logic [31:0] table_read_data_low,
  output logic [31:0] table_read_data_high
);

  // ==========================================================================
  // Storage and hashes
  logic [mall_pkg::ENT_W-1:0] tbl_mem [0:mall_pkg::TBL_DEPTH-1];
  mall_pkg::mall_ctl_type c_r;
  mall_pkg::mall_ctl_type c_nxt;
  logic mem_we;
  logic [mall_pkg::IDX_W-1:0] mem_widx;
  logic [mall_pkg::ENT_W-1:0] mem_wdata;
  logic [mall_pkg::IDX_W-1:0] dst_idx;
  logic [mall_pkg::IDX_W-1:0] src_idx;
  logic [mall_pkg::IDX_W-1:0] wr_idx;
  logic [mall_pkg::ENT_W-1:0] dst_ent;
  logic [mall_pkg::ENT_W-1:0] src_ent;
  logic [mall_pkg::ENT_W-1:0] wr_ent;
  logic [mall_pkg::ENT_W-1:0] idx_ent;
  logic [mall_pkg::ENT_W-1:0] scan_ent;
  logic [mall_pkg::ENT_W-1:0] host_ent;
  logic [mall_pkg::ENT_W-1:0] learn_ent;
  logic [mall_pkg::NUM_PORTS-1:0] src_onehot;
  logic dst_match;
  logic src_match;
  logic wr_match;

  mall_hash u_hash_dst (
    .mac(c_r.dmac),
    .idx(dst_idx)
  );

  mall_hash u_hash_src (
    .mac(c_r.smac),
    .idx(src_idx)
  );

  mall_hash u_hash_wr (
    .mac({c_r.wdh[15:0], c_r.wdl}),
    .idx(wr_idx)
  );

  assign dst_ent = tbl_mem[dst_idx];
  assign src_ent = tbl_mem[src_idx];
  assign wr_ent = tbl_mem[wr_idx];
  assign idx_ent = tbl_mem[c_r.idx];
  assign scan_ent = tbl_mem[c_r.scan_ptr[mall_pkg::IDX_W-1:0]];
  assign host_ent = {c_r.wdh[mall_pkg::F_VALID-mall_pkg::HI_OFS:0], c_r.wdl};
  assign dst_match = dst_ent[mall_pkg::F_VALID]
                   && (dst_ent[mall_pkg::F_MAC_HI:0] == c_r.dmac);
  assign src_match = src_ent[mall_pkg::F_VALID]
                   && (src_ent[mall_pkg::F_MAC_HI:0] == c_r.smac);
  assign wr_match = wr_ent[mall_pkg::F_VALID]
                  && (wr_ent[mall_pkg::F_MAC_HI:0] == host_ent[mall_pkg::F_MAC_HI:0]);
  assign src_onehot = 3'h1 << c_r.sport;

  // Fresh learned entry: one port, age set, not static, no filter or priority
  always_comb begin
    learn_ent = '0;
    learn_ent[mall_pkg::F_MAC_HI:0] = c_r.smac;
    learn_ent[mall_pkg::F_PORTS_HI:mall_pkg::F_PORTS_LO] = src_onehot;
    learn_ent[mall_pkg::F_AGE] = 1'b1;
    learn_ent[mall_pkg::F_VALID] = 1'b1;
  end

  // ==========================================================================
  // Next-state logic
  always_comb begin
    c_nxt = c_r;
    mem_we = 1'b0;
    mem_widx = c_r.idx;
    mem_wdata = '0;
    c_nxt.done = 1'b0;

    // Free-running aging timer; a scan may still be pending when it wraps
    if (c_r.age_cnt == AGE_PERIOD_CYCLES[mall_pkg::AGE_CNT_W-1:0] - 40'h1) begin
      c_nxt.age_cnt = '0;
    end else begin
      c_nxt.age_cnt = c_r.age_cnt + 40'h1;
    end

    case (c_r.state)
      mall_pkg::ST_INIT: begin
        mem_we = 1'b1;
        c_nxt.idx = c_r.idx + 9'h001;
        if (c_r.idx == 9'h1FF) begin
          c_nxt.state = mall_pkg::ST_IDLE;
        end
      end
      mall_pkg::ST_IDLE: begin
        if (c_r.make_pend) begin
          c_nxt.state = mall_pkg::ST_MAKE;
        end else if (c_r.age_req) begin
          c_nxt.age_req = 1'b0;
          c_nxt.idx = '0;
          c_nxt.state = mall_pkg::ST_AGE;
        end else if (lkp_req) begin
          c_nxt.dmac = lkp_dst_mac;
          c_nxt.smac = lkp_src_mac;
          c_nxt.sport = lkp_src_port;
          c_nxt.state = mall_pkg::ST_LOOK;
        end else if (c_r.scan_req) begin
          c_nxt.scan_req = 1'b0;
          c_nxt.state = mall_pkg::ST_SCAN;
        end
      end
      mall_pkg::ST_LOOK: begin
        c_nxt.done = 1'b1;
        c_nxt.hit = dst_match;
        c_nxt.ports = dst_match ? dst_ent[mall_pkg::F_PORTS_HI:mall_pkg::F_PORTS_LO]
                                : '0;
        c_nxt.filter = dst_match && dst_ent[mall_pkg::F_FILTER];
        c_nxt.prio_valid = dst_match && global_addr_prio_en
                         && dst_ent[mall_pkg::F_PRIO_EN];
        c_nxt.prio = dst_match ? dst_ent[mall_pkg::F_PRIO_HI:mall_pkg::F_PRIO_LO] : 3'h0;
        c_nxt.stp_ovr = dst_match && dst_ent[mall_pkg::F_STATIC]
                      && dst_ent[mall_pkg::F_AGE];
        c_nxt.state = mall_pkg::ST_LEARN;
      end
      mall_pkg::ST_LEARN: begin
        mem_widx = src_idx;
        if (port_learn_en[c_r.sport]) begin
          if (src_match) begin
            if (!src_ent[mall_pkg::F_STATIC]) begin
              mem_we = 1'b1;
              mem_wdata = src_ent;
              mem_wdata[mall_pkg::F_PORTS_HI:mall_pkg::F_PORTS_LO] = src_onehot;
              mem_wdata[mall_pkg::F_AGE] = 1'b1;
            end
          end else if (!src_ent[mall_pkg::F_VALID] || !src_ent[mall_pkg::F_STATIC]) begin
            // Slot collision evicts only a learned entry, never a static one
            mem_we = 1'b1;
            mem_wdata = learn_ent;
          end
        end
        c_nxt.state = mall_pkg::ST_IDLE;
      end
      mall_pkg::ST_MAKE: begin
        mem_widx = wr_idx;
        if (host_ent[mall_pkg::F_VALID]) begin
          mem_we = 1'b1;
          mem_wdata = host_ent;
        end else if (wr_match) begin
          mem_we = 1'b1;
          mem_wdata = '0;
        end
        c_nxt.make_pend = 1'b0;
        c_nxt.state = mall_pkg::ST_IDLE;
      end
      mall_pkg::ST_AGE: begin
        if (idx_ent[mall_pkg::F_VALID] && !idx_ent[mall_pkg::F_STATIC]) begin
          mem_we = 1'b1;
          if (idx_ent[mall_pkg::F_AGE]) begin
            mem_wdata = idx_ent;
            mem_wdata[mall_pkg::F_AGE] = 1'b0;
          end else begin
            mem_wdata = '0;
          end
        end
        c_nxt.idx = c_r.idx + 9'h001;
        if (c_r.idx == 9'h1FF) begin
          c_nxt.state = mall_pkg::ST_IDLE;
        end
      end
      mall_pkg::ST_SCAN: begin
        // Slot order walk: unrelated to learning order
        if (c_r.scan_ptr[mall_pkg::IDX_W]) begin
          c_nxt.rdh[mall_pkg::RDH_EOT] = 1'b1;
          c_nxt.state = mall_pkg::ST_IDLE;
        end else if (scan_ent[mall_pkg::F_VALID]) begin
          c_nxt.rdl = scan_ent[31:0];
          c_nxt.rdh = {5'h00, scan_ent[mall_pkg::F_VALID:mall_pkg::HI_OFS]};
          c_nxt.state = mall_pkg::ST_IDLE;
        end else begin
          c_nxt.scan_ptr = c_r.scan_ptr + 10'h001;
        end
      end
      default: begin
        c_nxt.state = mall_pkg::ST_IDLE;
      end
    endcase

    // Sets after clears so a coinciding event is never lost
    if (c_r.age_cnt == AGE_PERIOD_CYCLES[mall_pkg::AGE_CNT_W-1:0] - 40'h1) begin
      c_nxt.age_req = 1'b1;
    end

    // Host register writes
    if (wdl_wr) begin
      c_nxt.wdl = host_wdata;
    end
    if (wdh_wr) begin
      c_nxt.wdh = host_wdata;
    end
    if (cmd_wr && cmd_wdata[mall_pkg::CMD_MAKE]) begin
      c_nxt.make_pend = 1'b1;
    end
    if (cmd_wr && cmd_wdata[mall_pkg::CMD_GET_FIRST]) begin
      c_nxt.scan_ptr = '0;
      c_nxt.scan_req = 1'b1;
      c_nxt.rdh = '0;
    end else if (cmd_wr && cmd_wdata[mall_pkg::CMD_GET_NEXT]) begin
      // Stepping past end keeps the pointer parked at end-of-table
      if (!c_r.scan_ptr[mall_pkg::IDX_W]) begin
        c_nxt.scan_ptr = c_r.scan_ptr + 10'h001;
      end
      c_nxt.scan_req = 1'b1;
      c_nxt.rdh = '0;
    end

    c_nxt.ready = (c_nxt.state == mall_pkg::ST_IDLE) && !c_nxt.make_pend
                && !c_nxt.age_req;
  end

  // ==========================================================================
  // State registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      c_r <= '0;
      c_r.state <= mall_pkg::ST_INIT;
    end else begin
      c_r <= c_nxt;
    end
  end

  // Table write port; init walk clears every slot after reset
  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      tbl_mem[mem_widx] <= mem_wdata;
    end
  end

  // ==========================================================================
  // Outputs
  assign lkp_ready = c_r.ready;
  assign lkp_done = c_r.done;
  assign lkp_hit = c_r.hit;
  assign lkp_ports = c_r.ports;
  assign lkp_filter = c_r.filter;
  assign lkp_prio_valid = c_r.prio_valid;
  assign lkp_prio = c_r.prio;
  assign lkp_stp_override = c_r.stp_ovr;
  assign make_pending = c_r.make_pend;
  assign table_read_data_low = c_r.rdl;
  assign table_read_data_high = c_r.rdh;

endmodule : mall_table

//--- bench/mall_ingress_model.sv
// Purpose: Ingress-side requester that feeds lookups to the table
// Assumes: One request in flight, held until the ready edge takes it
// Notes: Released address lines flip so stale values never pass as live
`timescale 1ns/10ps
module mall_ingress_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic go,
  input wire logic [47:0] dst,
  input wire logic [47:0] src,
  input wire logic [1:0] port,
  input wire logic lkp_ready,
  output logic lkp_req = 1'h0,
  output logic [47:0] lkp_dst_mac = 48'h0,
  output logic [47:0] lkp_src_mac = 48'h0,
  output logic [1:0] lkp_src_port = 2'h0
);
  // ==========================================================================
  // Request hold and release
  always @(posedge clk_sys) begin
    if (rst) begin
      lkp_req <= 1'h0;
    end else if (go && !lkp_req) begin
      lkp_req <= 1'h1;
      lkp_dst_mac <= dst;
      lkp_src_mac <= src;
      lkp_src_port <= port;
    end else if (lkp_req && lkp_ready) begin
      lkp_req <= 1'h0;
      lkp_dst_mac <= ~lkp_dst_mac;
      lkp_src_mac <= ~lkp_src_mac;
      lkp_src_port <= ~lkp_src_port;
    end
  end
endmodule : mall_ingress_model

//--- bench/mall_table_checker.sv
// Purpose: Port-level timing checks on the address table
// Assumes: Single clock domain, synchronous reset
// Notes: Latencies follow the hand-over contract
`timescale 1ns/10ps
module mall_table_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic lkp_req,
  input wire logic lkp_ready,
  input wire logic lkp_done,
  input wire logic lkp_hit,
  input wire logic [mall_pkg::NUM_PORTS-1:0] lkp_ports,
  input wire logic lkp_prio_valid,
  input wire logic [2:0] lkp_prio,
  input wire logic lkp_stp_override,
  input wire logic cmd_wr,
  input wire logic [31:0] cmd_wdata,
  input wire logic make_pending,
  input wire logic [31:0] table_read_data_high
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [1:0] take_r;
  always_ff @(posedge clk_sys) begin
    take_r <= rst ? 2'h0 : {take_r[0], lkp_req && lkp_ready};
  end
  // ==========================================================================
  // Sequences and properties
  sequence s_take; lkp_req && lkp_ready; endsequence
  sequence s_make; cmd_wr && cmd_wdata[2]; endsequence
  sequence s_read; cmd_wr && !cmd_wdata[2] && (cmd_wdata[1] || cmd_wdata[0]); endsequence
  property p_done; s_take |=> !lkp_ready ##1 lkp_done; endproperty
  property p_spur; lkp_done |-> take_r[1]; endproperty
  property p_miss; lkp_done && !lkp_hit |-> lkp_ports == 3'h0 && lkp_prio == 3'h0; endproperty
  property p_prio; lkp_prio_valid |-> lkp_hit; endproperty
  property p_stp; lkp_stp_override |-> lkp_hit; endproperty
  property p_pend; s_make |=> make_pending; endproperty
  property p_commit; $rose(make_pending) |-> ##[1:600] !make_pending; endproperty
  property p_hold; make_pending |-> !lkp_ready; endproperty
  property p_rdclr; s_read |=> table_read_data_high == 32'h0; endproperty
  a_done: assert property (p_done) else $error("lookup answer not on time");
  a_spur: assert property (p_spur) else $error("answer without request");
  a_miss: assert property (p_miss) else $error("miss carries data");
  a_prio: assert property (p_prio) else $error("priority without hit");
  a_stp: assert property (p_stp) else $error("override without hit");
  a_pend: assert property (p_pend) else $error("pending not set");
  a_commit: assert property (p_commit) else $error("commit too slow");
  a_hold: assert property (p_hold) else $error("ready while pending");
  a_rdclr: assert property (p_rdclr) else $error("read data not cleared");
endmodule : mall_table_checker
bind mall_table mall_table_checker i_chk (.clk_sys(clk_sys), .rst(rst), .lkp_req(lkp_req),
  .lkp_ready(lkp_ready), .lkp_done(lkp_done), .lkp_hit(lkp_hit), .lkp_ports(lkp_ports),
  .lkp_prio_valid(lkp_prio_valid), .lkp_prio(lkp_prio), .lkp_stp_override(lkp_stp_override),
  .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata), .make_pending(make_pending),
  .table_read_data_high(table_read_data_high));

//--- bench/testbench.sv
// Purpose: Self-checking bench for the address table
// Assumes: Short aging period so two scans fit in the run
// Notes: Host side driven by tasks, packet side by the ingress model
`timescale 1ns/10ps
module testbench;
  localparam longint AGE = 2000;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0;
  logic gprio = 1'b0;
  logic [47:0] g_dst = 48'h0, g_src = 48'h0, m, a, b;
  logic [1:0] g_port = 2'h0;
  logic [2:0] len = 3'h3;
  logic [2:0] pt, lkp_ports, lkp_prio;
  logic [6:0] f;
  logic cmd_wr = 1'b0, wdl_wr = 1'b0, wdh_wr = 1'b0;
  logic [31:0] cmd_wdata = 32'h0, host_wdata = 32'h0, rdl, rdh;
  logic lkp_req, lkp_ready, lkp_done, lkp_hit, lkp_filter, lkp_prio_valid, lkp_stp, pend;
  logic [47:0] lkp_dst_mac, lkp_src_mac;
  logic [1:0] lkp_src_port;
  int fails = 0, total_checks = 0;
  always #2 clk_sys = ~clk_sys;
  mall_table #(.AGE_PERIOD_CYCLES(AGE)) i_dut (.clk_sys(clk_sys), .rst(rst),
    .lkp_req(lkp_req), .lkp_dst_mac(lkp_dst_mac), .lkp_src_mac(lkp_src_mac),
    .lkp_src_port(lkp_src_port), .lkp_ready(lkp_ready), .lkp_done(lkp_done),
    .lkp_hit(lkp_hit), .lkp_ports(lkp_ports), .lkp_filter(lkp_filter),
    .lkp_prio_valid(lkp_prio_valid), .lkp_prio(lkp_prio), .lkp_stp_override(lkp_stp),
    .port_learn_en(len), .global_addr_prio_en(gprio), .cmd_wr(cmd_wr),
    .cmd_wdata(cmd_wdata), .wdl_wr(wdl_wr), .wdh_wr(wdh_wr), .host_wdata(host_wdata),
    .make_pending(pend), .table_read_data_low(rdl), .table_read_data_high(rdh));
  mall_ingress_model i_ing (.clk_sys(clk_sys), .rst(rst), .go(go), .dst(g_dst),
    .src(g_src), .port(g_port), .lkp_ready(lkp_ready), .lkp_req(lkp_req),
    .lkp_dst_mac(lkp_dst_mac), .lkp_src_mac(lkp_src_mac), .lkp_src_port(lkp_src_port));
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] ehi(logic [15:0] mh, logic [2:0] p, logic [6:0] c, logic v);
    return {5'h0, v, c, p, mh};
  endfunction : ehi
  task automatic stop_test();
    if (fails == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic hw(input int sel, input logic [31:0] d);
    @(posedge clk_sys);
    cmd_wr <= (sel == 2);
    wdl_wr <= (sel == 0);
    wdh_wr <= (sel == 1);
    cmd_wdata <= d;
    host_wdata <= d;
    @(posedge clk_sys);
    {cmd_wr, wdl_wr, wdh_wr} <= 3'h0;
    host_wdata <= ~d;
  endtask : hw
  task automatic mk(input logic [31:0] lo, input logic [31:0] hi);
    hw(0, lo);
    hw(1, hi);
    hw(2, 32'h4);
    #1;
    chk(pend, 1'h1);
    for (int n = 0; n < 700 && pend !== 1'b0; n++) tick();
    chk(pend, 1'h0);
    hw(2, 32'h0);
  endtask : mk
  task automatic lk(input logic [47:0] d, input logic [47:0] s, input logic [1:0] p,
      input logic g);
    @(posedge clk_sys);
    go <= 1'b1;
    g_dst <= d;
    g_src <= s;
    g_port <= p;
    gprio <= g;
    @(posedge clk_sys);
    go <= 1'b0;
    for (int n = 0; n < 700 && lkp_done !== 1'b1; n++) tick();
    chk(lkp_done, 1'h1);
  endtask : lk
  task automatic rpoll(input logic [31:0] c);
    hw(2, c);
    hw(2, 32'h0);
    for (int n = 0; n < 700 && rdh[27:26] === 2'h0; n++) tick();
  endtask : rpoll
  // ==========================================================================
  // Scenarios
  initial begin
    void'($urandom(89062));
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    for (int n = 0; n < 700 && lkp_ready !== 1'b1; n++) tick();
    chk(lkp_ready, 1'h1);
    for (int i = 0; i < 4; i++) begin
      m = {16'($urandom), 32'($urandom)};
      pt = 3'($urandom) | 3'h1;
      // Static forced: host marks manual entries static
      f = 7'($urandom) | 7'h2;
      mk(m[31:0], ehi(m[47:32], pt, f, 1'b1));
      lk(m, m, 2'($urandom_range(1)), i[0]);
      chk(lkp_hit, 1'h1);
      chk(lkp_filter, f[2]);
      chk(lkp_stp, f[1] & f[0]);
      chk(lkp_prio_valid, i[0] & f[3]);
      chk(lkp_prio, f[6:4]);
      // Learning-enabled port whose one-hot differs from pt
      lk(m, m, 2'h1, 1'b0);
      chk(lkp_ports, pt);
      mk(m[31:0], ehi(m[47:32], pt, f, 1'b0));
      lk(m, m, 2'h2, 1'b0);
      chk(lkp_hit, 1'h0);
    end
    a = 48'h0A0B_0C0D_0E01;
    b = 48'h1A2B_3C4D_5E02;
    lk(b, a, 2'h1, 1'b0);
    lk(a, b, 2'h2, 1'b0);
    chk(lkp_ports, 3'h2);
    lk(b, a, 2'h0, 1'b0);
    chk(lkp_hit, 1'h0);
    lk(a, b, 2'h2, 1'b0);
    chk(lkp_ports, 3'h1);
    rpoll(32'h2);
    chk(rdh[26], 1'h1);
    chk(rdl, a[31:0]);
    chk(rdh[18:0], {3'h1, a[47:32]});
    rpoll(32'h1);
    chk(rdh[27:26], 2'h2);
    mk(b[31:0], ehi(b[47:32], 3'h4, 7'h02, 1'b1));
    lk(a, b, 2'h2, 1'b0);
    chk(lkp_hit, 1'h1);
    // Two full periods plus scan time guarantee removal
    repeat (2 * AGE + 1200) tick();
    lk(a, b, 2'h2, 1'b0);
    chk(lkp_hit, 1'h0);
    lk(b, a, 2'h2, 1'b0);
    chk(lkp_ports, 3'h4);
    @(posedge clk_sys);
    len <= 3'h7;
    lk(b, a, 2'h2, 1'b0);
    lk(a, b, 2'h1, 1'b0);
    chk(lkp_ports, 3'h4);
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    stop_test();
  end
endmodule : testbench
